// file: rtl/rds_params.svh
`ifndef RDS_PARAMS_SVH
`define RDS_PARAMS_SVH
// ----------------------------------------
// sizes
// ----------------------------------------
`define NUM_PAGES      32
`define NUM_GOUT       16
// ----------------------------------------
// command codes and paged field selectors
// ----------------------------------------
`define CMD_SELECTOR   8'hf7
`define FLD_ON_PAGE    8'h00
`define FLD_OFF_PAGE   8'h01
`define FLD_FOLLOWER   8'h02
`define FLD_ON_GOUT    8'h03
`define FLD_OFF_GOUT   8'h04
`define FLD_TIMING     8'h05
`define FLD_STATUS     8'h06
// ----------------------------------------
// field positions, codes and reset values
// ----------------------------------------
`define TIM_TON_LSB    0
`define TIM_TOFF_LSB   8
`define TIM_TO_LSB     16
`define TIM_ACT_LSB    24
`define STAT_TO_BIT    0
`define STAT_LATCH_BIT 1
`define OFF_ACT_GO     2'b01
`define SEL_RESET      5'h00
`define MASK_RESET     32'h0000_0000
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS  100
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES    (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// file: rtl/rds_pkg.sv
package rds_pkg;
  `include "rds_params.svh"

  typedef enum logic [5:0] {
    ST_OFF     = 6'b000001,
    ST_ON_DLY  = 6'b000010,
    ST_ON      = 6'b000100,
    ST_WAIT_OF = 6'b001000,
    ST_OFF_DLY = 6'b010000,
    ST_LATCHED = 6'b100000
  } page_state_t;

  typedef struct packed {
    page_state_t st;
    logic [7:0]  cnt;
    logic        to_flag;
    logic        pend;
    logic        en;
  } page_reg_t;

  typedef struct packed {
    logic [`NUM_PAGES-1:0][31:0] on_pg;
    logic [`NUM_PAGES-1:0][31:0] off_pg;
    logic [`NUM_PAGES-1:0][31:0] follow;
    logic [`NUM_PAGES-1:0][15:0] on_go;
    logic [`NUM_PAGES-1:0][15:0] off_go;
    logic [`NUM_PAGES-1:0][25:0] timing;
    logic [4:0]                  sel;
    logic [31:0]                 rdata;
    logic                        rvalid;
    logic                        nack;
    logic [`NUM_PAGES-1:0]       uv_rep;
  } seq_reg_t;
endpackage : rds_pkg

// file: rtl/tick_divider.sv
`timescale 1ns/1ns
`include "rds_params.svh"
module tick_divider
  import rds_pkg::*;
#(
  parameter int CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // slow enable
  output logic      o_tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } div_t;
  div_t s_ff, nxt_s;

  if (CYCLES < 1) begin : g_chk
    $error("tick divider needs at least one cycle");
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.cnt == 32'(CYCLES - 1)) begin
      nxt_s.cnt  = 32'h0000_0000;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_tick = s_ff.tick;
endmodule : tick_divider

// file: rtl/page_sequencer.sv
`timescale 1ns/1ns
`include "rds_params.svh"
module page_sequencer
  import rds_pkg::*;
(
  // clock, reset and tick
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_tick,
  // conditions
  input  wire logic       i_cmd_on,
  input  wire logic       i_on_ok,
  input  wire logic       i_off_ok,
  input  wire logic       i_kill,
  input  wire logic       i_clr_to,
  // configuration
  input  wire logic [7:0] i_ton,
  input  wire logic [7:0] i_toff,
  input  wire logic [7:0] i_off_to,
  input  wire logic [1:0] i_off_act,
  // results
  output logic            o_en,
  output logic            o_to_stat,
  output logic            o_latched
);
  page_reg_t s_ff, nxt_s;
  logic      to_hit;
  logic [7:0] cnt_inc;

  assign cnt_inc = (s_ff.cnt == 8'hff) ? s_ff.cnt : s_ff.cnt + 8'h01;
  // zero timeout means never monitored
  assign to_hit = i_tick && (i_off_to != 8'h00) && (cnt_inc == i_off_to);

  always_comb begin
    nxt_s = s_ff;
    if (i_kill) nxt_s.pend = 1'b1;
    unique case (s_ff.st)
      ST_OFF: begin
        if (i_kill) begin
          nxt_s.st = ST_LATCHED;
        end else if (i_cmd_on && i_on_ok) begin
          nxt_s.st  = ST_ON_DLY;
          nxt_s.cnt = 8'h00;
        end
      end
      ST_ON_DLY: begin
        if (i_kill) nxt_s.st = ST_LATCHED;
        else if (!i_cmd_on) nxt_s.st = ST_OFF;
        else if (s_ff.cnt >= i_ton) nxt_s.st = ST_ON;
        else if (i_tick) nxt_s.cnt = cnt_inc;
      end
      ST_ON: begin
        // dependencies on the way up are no longer looked at here
        if (i_kill || !i_cmd_on) begin
          nxt_s.st  = ST_WAIT_OF;
          nxt_s.cnt = 8'h00;
        end
      end
      ST_WAIT_OF: begin
        if (i_off_ok) begin
          nxt_s.st  = ST_OFF_DLY;
          nxt_s.cnt = 8'h00;
        end else if (i_tick) begin
          nxt_s.cnt = cnt_inc;
          if (to_hit && i_off_act == `OFF_ACT_GO) begin
            nxt_s.st  = ST_OFF_DLY;
            nxt_s.cnt = 8'h00;
          end
        end
      end
      ST_OFF_DLY: begin
        if (s_ff.cnt >= i_toff) nxt_s.st = nxt_s.pend ? ST_LATCHED : ST_OFF;
        else if (i_tick) nxt_s.cnt = cnt_inc;
      end
      ST_LATCHED: begin
        // only an off command releases the latch
        if (!i_cmd_on && !i_kill) begin
          nxt_s.st   = ST_OFF;
          nxt_s.pend = 1'b0;
        end
      end
      default: nxt_s.st = ST_OFF;
    endcase
    // the timeout event beats a clear in the same cycle
    nxt_s.to_flag = (s_ff.st == ST_WAIT_OF && to_hit) | (s_ff.to_flag & ~i_clr_to);
    nxt_s.en = nxt_s.st inside {ST_ON, ST_WAIT_OF, ST_OFF_DLY};
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_ff <= '{st: ST_OFF, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_en      = s_ff.en;
  assign o_to_stat = s_ff.to_flag;
  assign o_latched = (s_ff.st == ST_LATCHED);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_rise;
    !s_ff.en ##1 s_ff.en;
  endsequence
  property p_rise_cause;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_rise |-> $past(s_ff.st) == ST_ON_DLY && $past(i_cmd_on);
  endproperty
  rise_needs_on_a: assert property (p_rise_cause)
    else $error("enable rose without a pending on request");

  latch_holds_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_latched && i_cmd_on |=> o_latched && !s_ff.en)
    else $error("latched page left latch while still commanded on");

  zero_timeout_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_off_to == 8'h00 && !s_ff.to_flag |=> !s_ff.to_flag)
    else $error("timeout status raised with monitoring disabled");

  wait_holds_en_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_ff.st == ST_WAIT_OF && !i_off_ok && !to_hit |=> s_ff.en)
    else $error("enable dropped with off dependencies unmet");
endmodule : page_sequencer

// file: rtl/rail_dependency_sequencer.sv
// Behaviour
// - time each rail's power-down; unmet off dependencies past timeout set a status bit
// - a sequence-off timeout of zero disables the monitor for that rail
// - enable stays off until every page in the power-up page mask is good
// - enable stays on until every page in the power-down page mask has left good
// - each page holds a 32-bit follower mask; several followers allowed
// - a shutdown fault on a page also shuts down all its followers
// - with retries configured, followers run until the faulting page exhausts them
// - followers power down through their normal off path and turn-off delay
// - followers shut down this way never retry on their own
// - shut-down followers latch off; an off command must precede a new on
// - latching a follower off sets a reason bit in its vendor status word
// - in graceful shutdown, follower undervoltage faults are neither logged nor acted on
// - enable stays off until every output in the power-up output mask is asserted
// - once enabled, power-up output mask changes have no effect
// - enable stays on until every output in the power-down output mask drops
// - once disabled, power-down output mask changes have no effect
// - common byte command f7 stores the output index for later output setup
// - turn-on delay starts only when commanded on and power-up conditions met
// - off-timeout action 01 stops waiting and continues disabling; others wait on
`timescale 1ns/1ns
`include "rds_params.svh"
module rail_dependency_sequencer
  import rds_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  // host command port
  input  wire logic                  i_cmd_wr,
  input  wire logic                  i_cmd_rd,
  input  wire logic [7:0]            i_cmd_code,
  input  wire logic [4:0]            i_cmd_page,
  input  wire logic [31:0]           i_cmd_wdata,
  output logic [31:0]                o_cmd_rdata,
  output logic                       o_cmd_rvalid,
  output logic                       o_cmd_nack,
  output logic [4:0]                 o_output_setup_selector,
  // rail side
  input  wire logic [`NUM_PAGES-1:0] i_page_on,
  input  wire logic [`NUM_PAGES-1:0] i_power_good,
  input  wire logic [`NUM_GOUT-1:0]  i_general_output,
  input  wire logic [`NUM_PAGES-1:0] i_input_deps_met,
  output logic [`NUM_PAGES-1:0]      o_rail_enable,
  // fault side
  input  wire logic [`NUM_PAGES-1:0] i_fault,
  input  wire logic [`NUM_PAGES-1:0] i_fault_shutdown,
  input  wire logic [`NUM_PAGES-1:0] i_retries_spent,
  input  wire logic                  i_graceful,
  input  wire logic [`NUM_PAGES-1:0] i_undervoltage,
  output logic [`NUM_PAGES-1:0]      o_undervoltage_report,
  output logic [`NUM_PAGES-1:0]      o_no_retry,
  output logic [`NUM_PAGES-1:0]      o_seq_off_timeout,
  output logic [`NUM_PAGES-1:0]      o_vendor_status_word_latched
);
  seq_reg_t s_ff, nxt_s;

  logic [`NUM_PAGES-1:0] fault_fire;
  logic [`NUM_PAGES-1:0] kill;
  logic [`NUM_PAGES-1:0] on_ok;
  logic [`NUM_PAGES-1:0] off_ok;
  logic [`NUM_PAGES-1:0] clr_to;
  logic [`NUM_PAGES-1:0] follower_any;
  logic                  tick;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("tick period must be at least one clock");
  end

  // ----------------------------------------
  // millisecond time base for all delays
  // ----------------------------------------
  tick_divider #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .o_tick  (tick)
  );

  // ----------------------------------------
  // fault propagation to followers
  // ----------------------------------------
  // a retrying page is not yet dead, so its followers keep running
  assign fault_fire = i_fault & i_fault_shutdown & i_retries_spent;

  always_comb begin
    kill = '0;
    follower_any = '0;
    for (int p = 0; p < `NUM_PAGES; p++) begin
      if (fault_fire[p]) kill = kill | s_ff.follow[p];
      follower_any = follower_any | s_ff.follow[p];
    end
  end

  // ----------------------------------------
  // per page dependency evaluation and sequencer
  // ----------------------------------------
  for (genvar p = 0; p < `NUM_PAGES; p++) begin : g_page
    // an all-zero mask passes by construction
    assign on_ok[p] = &(~s_ff.on_pg[p] | i_power_good)
                    & &(~s_ff.on_go[p] | i_general_output)
                    & i_input_deps_met[p];
    assign off_ok[p] = &(~s_ff.off_pg[p] | ~i_power_good)
                     & &(~s_ff.off_go[p] | ~i_general_output);
    assign clr_to[p] = i_cmd_wr && i_cmd_code == `FLD_STATUS && i_cmd_page == 5'(p)
                     && i_cmd_wdata[`STAT_TO_BIT];

    page_sequencer u_page (
      .i_clk     (i_clk),
      .i_rst_b   (i_rst_b),
      .i_tick    (tick),
      .i_cmd_on  (i_page_on[p]),
      .i_on_ok   (on_ok[p]),
      .i_off_ok  (off_ok[p]),
      .i_kill    (kill[p]),
      .i_clr_to  (clr_to[p]),
      .i_ton     (s_ff.timing[p][`TIM_TON_LSB +: 8]),
      .i_toff    (s_ff.timing[p][`TIM_TOFF_LSB +: 8]),
      .i_off_to  (s_ff.timing[p][`TIM_TO_LSB +: 8]),
      .i_off_act (s_ff.timing[p][`TIM_ACT_LSB +: 2]),
      .o_en      (o_rail_enable[p]),
      .o_to_stat (o_seq_off_timeout[p]),
      .o_latched (o_vendor_status_word_latched[p])
    );
  end

  // a latched follower never retries; its own retry logic watches this
  assign o_no_retry = o_vendor_status_word_latched;

  // ----------------------------------------
  // command port and configuration store
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.rvalid = 1'b0;
    nxt_s.nack   = 1'b0;
    // graceful shutdown hides follower undervoltage from logging and response
    nxt_s.uv_rep = i_undervoltage & ~(i_graceful ? follower_any : '0);
    if (i_cmd_wr) begin
      unique case (i_cmd_code)
        `CMD_SELECTOR: nxt_s.sel = i_cmd_wdata[4:0];
        `FLD_ON_PAGE:  nxt_s.on_pg[i_cmd_page] = i_cmd_wdata;
        `FLD_OFF_PAGE: nxt_s.off_pg[i_cmd_page] = i_cmd_wdata;
        `FLD_FOLLOWER: nxt_s.follow[i_cmd_page] = i_cmd_wdata;
        `FLD_ON_GOUT:  nxt_s.on_go[i_cmd_page] = i_cmd_wdata[15:0];
        `FLD_OFF_GOUT: nxt_s.off_go[i_cmd_page] = i_cmd_wdata[15:0];
        `FLD_TIMING:   nxt_s.timing[i_cmd_page] = i_cmd_wdata[25:0];
        `FLD_STATUS:   nxt_s.nack = 1'b0;
        default:       nxt_s.nack = 1'b1;
      endcase
    end else if (i_cmd_rd) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata  = 32'h0000_0000;
      unique case (i_cmd_code)
        `CMD_SELECTOR: nxt_s.rdata = {27'h0000000, s_ff.sel};
        `FLD_ON_PAGE:  nxt_s.rdata = s_ff.on_pg[i_cmd_page];
        `FLD_OFF_PAGE: nxt_s.rdata = s_ff.off_pg[i_cmd_page];
        `FLD_FOLLOWER: nxt_s.rdata = s_ff.follow[i_cmd_page];
        `FLD_ON_GOUT:  nxt_s.rdata = {16'h0000, s_ff.on_go[i_cmd_page]};
        `FLD_OFF_GOUT: nxt_s.rdata = {16'h0000, s_ff.off_go[i_cmd_page]};
        `FLD_TIMING:   nxt_s.rdata = {6'h00, s_ff.timing[i_cmd_page]};
        `FLD_STATUS: begin
          nxt_s.rdata[`STAT_TO_BIT]    = o_seq_off_timeout[i_cmd_page];
          nxt_s.rdata[`STAT_LATCH_BIT] = o_vendor_status_word_latched[i_cmd_page];
        end
        default:       nxt_s.nack = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_ff     <= '0;
      s_ff.sel <= `SEL_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_cmd_rdata             = s_ff.rdata;
  assign o_cmd_rvalid            = s_ff.rvalid;
  assign o_cmd_nack              = s_ff.nack;
  assign o_output_setup_selector = s_ff.sel;
  assign o_undervoltage_report   = s_ff.uv_rep;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_sel_write;
    i_cmd_wr && i_cmd_code == `CMD_SELECTOR;
  endsequence
  sequence s_sel_read;
    !i_cmd_wr && i_cmd_rd && i_cmd_code == `CMD_SELECTOR;
  endsequence

  selector_store_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_sel_write |=> o_output_setup_selector == $past(i_cmd_wdata[4:0]))
    else $error("selector write not stored");

  selector_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_sel_read |=> o_cmd_rvalid && o_cmd_rdata == {27'h0000000, o_output_setup_selector})
    else $error("selector read back wrong");

  uv_mask_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_graceful |=> (o_undervoltage_report & $past(follower_any)) == '0)
    else $error("follower undervoltage reported during graceful shutdown");

  follower_kill_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_fault & i_fault_shutdown & ~i_retries_spent) != '0 && fault_fire == '0
      |-> kill == '0)
    else $error("followers shut down before retries were spent");
endmodule : rail_dependency_sequencer

// file: dv/rail_regulator_model.sv
`timescale 1ns/1ns
`include "rds_params.svh"
// ----------------------------------------
// regulator bank: power-good trails each enable by a fixed lag
// ----------------------------------------
module rail_regulator_model
  import rds_pkg::*;
#(
  parameter int LAG = 3
) (
  // clock
  input  wire logic                  i_clk,
  // rail side
  input  wire logic [`NUM_PAGES-1:0] i_rail_enable,
  output logic [`NUM_PAGES-1:0]      o_power_good
);
  logic [LAG-1:0][`NUM_PAGES-1:0] pipe_ff;

  // a real rail ramps, so good never follows enable in the same cycle
  initial pipe_ff = '0;
  always @(posedge i_clk) begin
    pipe_ff <= {pipe_ff[LAG-2:0], i_rail_enable};
  end
  assign o_power_good = pipe_ff[LAG-1];
endmodule : rail_regulator_model

// file: dv/rail_dependency_sequencer_bench.sv
`timescale 1ns/1ns
`include "rds_params.svh"
module rail_dependency_sequencer_bench
  import rds_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  code = 8'h00;
  logic [4:0]  pg = 5'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdata;
  logic        rvalid;
  logic        nack;
  logic [4:0]  sel;
  logic [31:0] page_on = '0;
  logic [31:0] good;
  logic [15:0] gout = '0;
  logic [31:0] in_ok = '1;
  logic [31:0] shut = '1;
  logic [31:0] fault = '0;
  logic [31:0] spent = '0;
  logic        graceful = 1'b0;
  logic [31:0] uv = '0;
  logic [31:0] en;
  logic [31:0] uv_rep;
  logic [31:0] no_retry;
  logic [31:0] to_stat;
  logic [31:0] latched;
  int          n_mismatch = 0;
  int          num_checks = 0;

  always #50 i_clk = ~i_clk;

  rail_dependency_sequencer #(.TICK_CYCLES(4)) u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_wr(wr), .i_cmd_rd(rd), .i_cmd_code(code),
    .i_cmd_page(pg), .i_cmd_wdata(wd), .o_cmd_rdata(rdata), .o_cmd_rvalid(rvalid),
    .o_cmd_nack(nack), .o_output_setup_selector(sel), .i_page_on(page_on),
    .i_power_good(good), .i_general_output(gout), .i_input_deps_met(in_ok),
    .o_rail_enable(en), .i_fault(fault), .i_fault_shutdown(shut),
    .i_retries_spent(spent), .i_graceful(graceful), .i_undervoltage(uv),
    .o_undervoltage_report(uv_rep), .o_no_retry(no_retry), .o_seq_off_timeout(to_stat),
    .o_vendor_status_word_latched(latched));

  rail_regulator_model u_reg (.i_clk(i_clk), .i_rail_enable(en), .o_power_good(good));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc

  task wcmd(input logic [7:0] c, input logic [4:0] p, input logic [31:0] d);
    @(negedge i_clk);
    {wr, code, pg, wd} = {1'b1, c, p, d};
    @(negedge i_clk);
    wr = 1'b0;
  endtask : wcmd

  // answer registered at the taking edge, so it is visible one negedge later
  task rcmd(input logic [7:0] c, input logic [4:0] p, input logic [31:0] e,
            input logic n, input string m);
    @(negedge i_clk);
    {rd, code, pg} = {1'b1, c, p};
    @(negedge i_clk);
    rd = 1'b0;
    chk(nack === n && rvalid === 1'b1 && rdata === e, m);
  endtask : rcmd

  // bounded wait on one enable; a miss is reported by the compare
  task wen(input int p, input logic v, input int n, input string m);
    for (int i = 0; i < n && en[p] !== v; i++) cyc(1);
    chk(en[p] === v, m);
  endtask : wen

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    chk(sel === 5'h00 && en === 32'h0 && to_stat === 32'h0, "reset state");
    wcmd(`CMD_SELECTOR, 5'h00, 32'h0000_0013);
    chk(sel === 5'h13, "selector level");
    rcmd(`CMD_SELECTOR, 5'h07, 32'h0000_0013, 1'b0, "selector readback");
    wcmd(`FLD_FOLLOWER, 5'h09, 32'ha5a5_0f0f);
    rcmd(`FLD_FOLLOWER, 5'h09, 32'ha5a5_0f0f, 1'b0, "mask readback");
    rcmd(`FLD_FOLLOWER, 5'h0a, 32'h0000_0000, 1'b0, "per page copy");
    wcmd(`FLD_ON_GOUT, 5'h0b, 32'hffff_ffff);
    rcmd(`FLD_ON_GOUT, 5'h0b, 32'h0000_ffff, 1'b0, "narrow field");
    wcmd(`FLD_ON_GOUT, 5'h0b, 32'h0000_0000);
    rcmd(8'h40, 5'h00, 32'h0000_0000, 1'b1, "unmapped code");
    $display("test regs done");
  endtask : t_regs

  task t_page_on;
    wcmd(`FLD_ON_PAGE, 5'h01, 32'h0000_0001);
    page_on[1] = 1'b1;
    cyc(20);
    chk(en[1] === 1'b0, "waits on page 0 good");
    in_ok[0] = 1'b0;
    page_on[0] = 1'b1;
    cyc(10);
    chk(en[0] === 1'b0, "waits on input condition");
    in_ok[0] = 1'b1;
    wen(0, 1'b1, 6, "unmasked page rises");
    wen(1, 1'b1, 10, "rises after page 0 good");
    $display("test page_on done");
  endtask : t_page_on

  task t_gout;
    wcmd(`FLD_ON_GOUT, 5'h02, 32'h0000_0008);
    wcmd(`FLD_OFF_GOUT, 5'h02, 32'h0000_0008);
    page_on[2] = 1'b1;
    cyc(20);
    chk(en[2] === 1'b0, "waits on output 3");
    gout[3] = 1'b1;
    wen(2, 1'b1, 6, "rises with output 3");
    gout[3] = 1'b0;
    cyc(10);
    chk(en[2] === 1'b1, "on mask ignored once on");
    gout[3] = 1'b1;
    page_on[2] = 1'b0;
    cyc(20);
    chk(en[2] === 1'b1, "waits on output 3 low");
    gout[3] = 1'b0;
    wen(2, 1'b0, 6, "falls with output 3");
    gout[3] = 1'b1;
    cyc(10);
    chk(en[2] === 1'b0, "off mask ignored once off");
    $display("test gout done");
  endtask : t_gout

  task t_timeout;
    // off timeout 2 ticks, action 01 on page 5; timeout 0 on page 7
    wcmd(`FLD_OFF_PAGE, 5'h05, 32'h0000_0040);
    wcmd(`FLD_OFF_PAGE, 5'h07, 32'h0000_0040);
    wcmd(`FLD_TIMING, 5'h05, 32'h0102_0000);
    wcmd(`FLD_TIMING, 5'h07, 32'h0100_0000);
    rcmd(`FLD_TIMING, 5'h05, 32'h0102_0000, 1'b0, "timing readback");
    page_on[7:5] = 3'b111;
    wen(7, 1'b1, 10, "page 7 on");
    cyc(5);
    page_on[5] = 1'b0;
    page_on[7] = 1'b0;
    cyc(3);
    chk(en[5] === 1'b1 && to_stat[5] === 1'b0, "waits on page 6");
    wen(5, 1'b0, 20, "action 01 carries on");
    chk(to_stat[5] === 1'b1, "timeout flagged");
    rcmd(`FLD_STATUS, 5'h05, 32'h0000_0001, 1'b0, "status timeout bit");
    cyc(40);
    chk(en[7] === 1'b1 && to_stat[7] === 1'b0, "zero timeout off");
    page_on[6] = 1'b0;
    wen(7, 1'b0, 20, "falls after page 6 leaves good");
    wcmd(`FLD_STATUS, 5'h05, 32'h0000_0001);
    chk(to_stat[5] === 1'b0, "timeout cleared");
    $display("test timeout done");
  endtask : t_timeout

  task t_follow;
    wcmd(`FLD_FOLLOWER, 5'h03, 32'h0000_0010);
    page_on[4:3] = 2'b11;
    wen(4, 1'b1, 10, "follower on");
    fault[3] = 1'b1;
    cyc(1);
    fault[3] = 1'b0;
    cyc(20);
    chk(en[4] === 1'b1 && latched[4] === 1'b0, "runs during retries");
    spent[3] = 1'b1;
    shut[3] = 1'b0;
    fault[3] = 1'b1;
    cyc(1);
    fault[3] = 1'b0;
    cyc(10);
    chk(en[4] === 1'b1 && latched[4] === 1'b0, "no shutdown response");
    shut[3] = 1'b1;
    fault[3] = 1'b1;
    cyc(1);
    fault[3] = 1'b0;
    wen(4, 1'b0, 20, "follower shut down");
    chk(latched[4] === 1'b1, "reason bit");
    rcmd(`FLD_STATUS, 5'h04, 32'h0000_0002, 1'b0, "status latch bit");
    chk(no_retry[4] === 1'b1, "no retry");
    cyc(20);
    chk(en[4] === 1'b0, "stays latched with on held");
    page_on[4] = 1'b0;
    cyc(2);
    page_on[4] = 1'b1;
    wen(4, 1'b1, 10, "restart after off then on");
    chk(latched[4] === 1'b0, "reason bit released");
    $display("test follow done");
  endtask : t_follow

  task t_graceful;
    graceful = 1'b1;
    uv[4] = 1'b1;
    uv[12] = 1'b1;
    cyc(2);
    chk(uv_rep[4] === 1'b0 && uv_rep[12] === 1'b1, "follower undervoltage dropped");
    graceful = 1'b0;
    cyc(2);
    chk(uv_rep[4] === 1'b1, "reported outside graceful");
    uv = '0;
    $display("test graceful done");
  endtask : t_graceful

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_b = 1'b1;
    t_regs();
    t_page_on();
    t_gout();
    t_timeout();
    t_follow();
    t_graceful();
    summarize();
  end

  // all tests take well under 2000 cycles
  initial begin
    #(20000 * 100);
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : rail_dependency_sequencer_bench
